// File: rtl/async_serial_port_9bit.sv
// full duplex asynchronous serial port with 8-bit and 9-bit frames
`timescale 1ns/1ns
// How it works
// RULE1: 8-bit frame is low start, eight data bits lsb first, one stop.
// RULE2: 9-bit frame adds ninth bit from ninth_transmit_bit before the stop.
// RULE3: control bit 7 picks the frame format, 0 eight-bit, 1 nine-bit.
// RULE4: every write to the data address loads and starts a transmission.
// RULE5: transmit_done_flag sets when the stop bit begins.
// RULE6: frames are received only while receive_enable_bit is 1.
// RULE7: 8-bit mode stores byte and stop bit if flag clear and, with control bit 5 set, stop ok.
// RULE8: 9-bit mode stores byte and ninth bit if flag clear and address ok.
// RULE9: failed checks leave buffer, ninth_receive_bit and receive flag untouched.
// RULE10: on overrun the first byte stays, the later frame is dropped.
// RULE11: receive shifter is separate from the buffer read by software.
// RULE12: data address writes go to transmit, reads come from receive buffer.
// RULE13: interrupt follows either flag when enabled; flags never self-clear.
// RULE14: software clears both done flags after servicing them.
// RULE15: bit clocks are half the timer overflow rate.
// RULE16: hidden receive timer shares reload and restarts on a start edge.
// RULE17: timer clock is sysclk/4, /12, /48, oscillator/8 or external pin.
// RULE18: software sets reload so overflows run at twice the baud rate.
// RULE19: control bit 6 reads as 1 and ignores writes.
// RULE20: receive_done_flag sets when the stop bit is sampled.
// RULE21: a master sends addresses with ninth bit 1, data with 0.
// RULE22: ninth_transmit_bit does nothing in 8-bit mode.
// RULE23: transmit line idles high; a falling receive edge starts a frame.
module async_serial_port_9bit
(
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire uart9_pkg::sfr_bus_t   sfr,
  output logic [7:0]                 sfr_rdata,
  input  wire logic                  int_enable,
  input  wire uart9_pkg::timer_cfg_t tcfg,
  input  wire logic                  ext_osc_pin,
  input  wire logic                  baud_timer_ext_input,
  input  wire logic                  serial_in_pin,
  output logic                       serial_out_pin,
  output logic                       irq
);
  import uart9_pkg::*;
  `include "uart9_consts.svh"

  logic [`SYNC_WIDTH-1:0] s1_q, s2_q, s3_q;
  logic       rx_lvl, rx_fall, osc_rise, ext_rise;
  logic       tx_tick, rx_sample, rx_restart;
  logic       wr_ctrl, wr_data;
  logic [7:0] ctrl_q, ctrl_d, rbuf_q, rbuf_d, rdata_q, rdata_d;
  logic       irq_q, irq_d;
  ser_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [2:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic       tx_out_q, tx_out_d, tx_pend_q, tx_pend_d;
  logic       bit9_q, bit9_d;
  logic       ti_set, rx_store, rx_bit_ok, rb8_new;

  //////////////////////////////////////////////////////////////////////////////
  // pins come from outside the clock domain; only s2/s3 feed logic
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end
    else
    begin
      s1_q <= {serial_in_pin, ext_osc_pin, baud_timer_ext_input};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges from the synchronised copies
  assign rx_lvl   = s2_q[2];
  assign rx_fall  = !s2_q[2] && s3_q[2];                               // RULE23
  assign osc_rise = s2_q[1] && !s3_q[1];
  assign ext_rise = s2_q[0] && !s3_q[0];
  assign wr_ctrl  = sfr.wr && (sfr.addr == `CTRL_ADDR);
  assign wr_data  = sfr.wr && (sfr.addr == `DATA_ADDR);                // RULE12
  assign rx_restart = (rx_st_q == SER_IDLE) && ctrl_q[`CTRL_REN_BIT] && rx_fall;

  baud_timer i_baud_timer (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cfg        (tcfg),
    .osc_rise   (osc_rise),
    .ext_rise   (ext_rise),
    .rx_restart (rx_restart),
    .tx_tick    (tx_tick),
    .rx_sample  (rx_sample)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transmitter: a write aborts any frame and queues the new byte for next tick
  always_comb
  begin
    tx_st_d   = tx_st_q;
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_out_d  = tx_out_q;
    tx_pend_d = tx_pend_q;
    ti_set    = 1'b0;
    if (tx_tick)
    begin
      case (tx_st_q)
        SER_IDLE, SER_STOP:
        begin
          tx_out_d = !tx_pend_q;                                       // RULE23
          tx_st_d  = tx_pend_q ? SER_START : SER_IDLE;
          tx_pend_d = 1'b0;
        end
        SER_START:
        begin
          tx_out_d = tx_sh_q[0];                                       // RULE1
          tx_sh_d  = {1'b0, tx_sh_q[7:1]};
          tx_cnt_d = 3'h0;
          tx_st_d  = SER_DATA;
        end
        SER_DATA:
        begin
          if (tx_cnt_q == `LAST_DATA_IDX)
          begin
            if (ctrl_q[`CTRL_MODE_BIT])                                // RULE3
            begin
              tx_out_d = ctrl_q[`CTRL_TB8_BIT];                        // RULE2 RULE22
              tx_st_d  = SER_NINTH;
            end
            else
            begin
              tx_out_d = 1'b1;
              tx_st_d  = SER_STOP;
              ti_set   = 1'b1;                                         // RULE5
            end
          end
          else
          begin
            tx_out_d = tx_sh_q[0];
            tx_sh_d  = {1'b0, tx_sh_q[7:1]};
            tx_cnt_d = tx_cnt_q + 3'h1;
          end
        end
        SER_NINTH:
        begin
          tx_out_d = 1'b1;
          tx_st_d  = SER_STOP;
          ti_set   = 1'b1;                                             // RULE5
        end
        default:
        begin
          tx_out_d = 1'b1;
          tx_st_d  = SER_IDLE;
        end
      endcase
    end
    if (wr_data)
    begin
      tx_sh_d   = sfr.wdata;                                           // RULE4
      tx_pend_d = 1'b1;
      tx_out_d  = 1'b1;
      tx_st_d   = SER_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver: shifter feeds the buffer only when the checks pass
  always_comb
  begin
    rx_st_d   = rx_st_q;
    rx_sh_d   = rx_sh_q;
    rx_cnt_d  = rx_cnt_q;
    bit9_d    = bit9_q;
    rx_store  = 1'b0;
    rx_bit_ok = ctrl_q[`CTRL_MODE_BIT] ? bit9_q : rx_lvl;
    rb8_new   = rx_bit_ok;
    case (rx_st_q)
      SER_IDLE:
        if (rx_restart)
          rx_st_d = SER_START;
      SER_START:
        if (rx_sample)
        begin
          // a glitch that is high again mid start bit is a false start
          rx_st_d  = rx_lvl ? SER_IDLE : SER_DATA;
          rx_cnt_d = 3'h0;
        end
      SER_DATA:
        if (rx_sample)
        begin
          rx_sh_d = {rx_lvl, rx_sh_q[7:1]};                            // RULE1
          if (rx_cnt_q == `LAST_DATA_IDX)
            rx_st_d = ctrl_q[`CTRL_MODE_BIT] ? SER_NINTH : SER_STOP;   // RULE3
          else
            rx_cnt_d = rx_cnt_q + 3'h1;
        end
      SER_NINTH:
        if (rx_sample)
        begin
          bit9_d  = rx_lvl;                                            // RULE2
          rx_st_d = SER_STOP;
        end
      SER_STOP:
        if (rx_sample)
        begin
          rx_st_d  = SER_IDLE;
          // overrun and filter both block the store, the old byte stays
          rx_store = !ctrl_q[`CTRL_RI_BIT] &&                          // RULE7 RULE8 RULE10
                     (!ctrl_q[`CTRL_MCE_BIT] || rx_bit_ok);
        end
      default: rx_st_d = SER_IDLE;
    endcase
    if (!ctrl_q[`CTRL_REN_BIT])
      rx_st_d = SER_IDLE;                                              // RULE6
  end

  //////////////////////////////////////////////////////////////////////////////
  // control, receive buffer, read data and interrupt; hardware set beats clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    rbuf_d = rbuf_q;
    if (wr_ctrl)
      ctrl_d = sfr.wdata;                                              // RULE14
    ctrl_d[`CTRL_ONE_BIT] = 1'b1;                                      // RULE19
    if (ti_set)
      ctrl_d[`CTRL_TI_BIT] = 1'b1;
    if (rx_store)
    begin
      rbuf_d = rx_sh_q;                                                // RULE11 RULE9
      ctrl_d[`CTRL_RB8_BIT] = rb8_new;
      ctrl_d[`CTRL_RI_BIT]  = 1'b1;                                    // RULE20
    end
    rdata_d = rdata_q;
    if (sfr.rd)
    begin
      case (sfr.addr)
        `CTRL_ADDR: rdata_d = ctrl_q;
        `DATA_ADDR: rdata_d = rbuf_q;                                  // RULE12
        default:    rdata_d = 8'h00;
      endcase
    end
    // only the flags raise the line; clearing them is left to software
    irq_d = int_enable && (ctrl_q[`CTRL_TI_BIT] || ctrl_q[`CTRL_RI_BIT]); // RULE13
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q    <= `CTRL_RESET;
      rbuf_q    <= `DATA_RESET;
      rdata_q   <= 8'h00;
      irq_q     <= 1'b0;
      tx_st_q   <= SER_IDLE;
      tx_sh_q   <= 8'h00;
      tx_cnt_q  <= 3'h0;
      tx_out_q  <= 1'b1;
      tx_pend_q <= 1'b0;
      rx_st_q   <= SER_IDLE;
      rx_sh_q   <= 8'h00;
      rx_cnt_q  <= 3'h0;
      bit9_q    <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      rbuf_q    <= rbuf_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
      tx_st_q   <= tx_st_d;
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_out_q  <= tx_out_d;
      tx_pend_q <= tx_pend_d;
      rx_st_q   <= rx_st_d;
      rx_sh_q   <= rx_sh_d;
      rx_cnt_q  <= rx_cnt_d;
      bit9_q    <= bit9_d;
    end
  end

  assign sfr_rdata      = rdata_q;
  assign serial_out_pin = tx_out_q;
  assign irq            = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seq_last_data;
    tx_tick && tx_st_q == SER_DATA && tx_cnt_q == `LAST_DATA_IDX;
  endsequence

  sequence seq_stop_entry;
    (seq_last_data ##0 !ctrl_q[`CTRL_MODE_BIT]) or
    (tx_tick && tx_st_q == SER_NINTH);
  endsequence

  a_ti_at_stop: assert property (seq_stop_entry |=>                    // RULE5
    ctrl_q[`CTRL_TI_BIT] && tx_out_q && (tx_st_q == SER_STOP || $past(wr_data)))
    else $error("transmit flag not set at stop bit");
  a_start_low: assert property ($rose(tx_st_q == SER_START) |-> !tx_out_q) // RULE1
    else $error("start bit not low");
  a_idle_high: assert property (tx_st_q == SER_IDLE |-> tx_out_q)      // RULE23
    else $error("transmit line not idle high");
  a_write_starts: assert property (wr_data |=> tx_pend_q && tx_sh_q == $past(sfr.wdata)) // RULE4
    else $error("write did not queue a frame");
  a_bit6_one: assert property (sfr.rd && sfr.addr == `CTRL_ADDR |=> sfr_rdata[6]) // RULE19
    else $error("control bit 6 not read as one");
  a_data_read: assert property (sfr.rd && sfr.addr == `DATA_ADDR |=>  // RULE12
    sfr_rdata == $past(rbuf_q))
    else $error("data read not from receive buffer");
  a_overrun_keep: assert property (ctrl_q[`CTRL_RI_BIT] && !wr_ctrl |=> // RULE10
    $stable(rbuf_q))
    else $error("buffer overwritten while full");
  a_ren_gate: assert property (!ctrl_q[`CTRL_REN_BIT] [*2] |-> rx_st_q == SER_IDLE) // RULE6
    else $error("receiver active while disabled");
  a_irq_flags: assert property (int_enable &&                          // RULE13
    (ctrl_q[`CTRL_TI_BIT] || ctrl_q[`CTRL_RI_BIT]) |=> irq)
    else $error("interrupt missing for set flag");

endmodule

// File: inc/uart9_consts.svh
// register map, field positions, reset values and divider counts of the serial port
`ifndef UART9_CONSTS_SVH
`define UART9_CONSTS_SVH

`define CTRL_ADDR      8'h98
`define DATA_ADDR      8'h99
`define CTRL_RESET     8'h40
`define DATA_RESET     8'h00
`define CTRL_MODE_BIT  7
`define CTRL_ONE_BIT   6
`define CTRL_MCE_BIT   5
`define CTRL_REN_BIT   4
`define CTRL_TB8_BIT   3
`define CTRL_RB8_BIT   2
`define CTRL_TI_BIT    1
`define CTRL_RI_BIT    0
`define LAST_DATA_IDX  3'h7
`define PRE_DIV_SYS4   6'h04
`define PRE_DIV_SYS12  6'h0c
`define PRE_DIV_SYS48  6'h30
`define PRE_DIV_OSC8   6'h08
`define PRE_DIV_EXT    6'h01
`define TIMER_TOP      8'hff
`define SYNC_WIDTH     3

`endif

// File: inc/uart9_pkg.sv
// types shared by the serial port and its baud timer
package uart9_pkg;

  typedef enum logic [2:0] {
    SRC_SYS12 = 3'h0,
    SRC_SYS4  = 3'h1,
    SRC_SYS48 = 3'h2,
    SRC_OSC8  = 3'h3,
    SRC_EXT   = 3'h4
  } clk_src_t;

  typedef enum logic [4:0] {
    SER_IDLE  = 5'h01,
    SER_START = 5'h02,
    SER_DATA  = 5'h04,
    SER_NINTH = 5'h08,
    SER_STOP  = 5'h10
  } ser_state_t;

  // one special-function-register access, single cycle strobes
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_bus_t;

  // baud timer setup, owned by the timer block outside this port
  typedef struct packed {
    logic       run;
    clk_src_t   src;
    logic [7:0] reload;
  } timer_cfg_t;

endpackage

// File: rtl/baud_timer.sv
// auto-reload baud timer with hidden receive copy and divide-by-two bit clocks
`timescale 1ns/1ns
module baud_timer
(
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire uart9_pkg::timer_cfg_t cfg,
  input  wire logic                  osc_rise,
  input  wire logic                  ext_rise,
  input  wire logic                  rx_restart,
  output logic                       tx_tick,
  output logic                       rx_sample
);
  import uart9_pkg::*;
  `include "uart9_consts.svh"

  logic [5:0] pre_q, pre_d;
  logic [5:0] pre_lim;
  logic       pre_ev, tick;
  logic [7:0] tl_q, tl_d, rxt_q, rxt_d;
  logic       tdiv_q, tdiv_d, rdiv_q, rdiv_d;
  logic       tx_ovf, rx_ovf;

  //////////////////////////////////////////////////////////////////////////////
  // input clock selection and prescaler
  always_comb
  begin
    pre_lim = `PRE_DIV_SYS12;
    pre_ev  = 1'b1;
    case (cfg.src)
      SRC_SYS4:  pre_lim = `PRE_DIV_SYS4;                             // RULE17
      SRC_SYS12: pre_lim = `PRE_DIV_SYS12;
      SRC_SYS48: pre_lim = `PRE_DIV_SYS48;
      SRC_OSC8:
      begin
        pre_lim = `PRE_DIV_OSC8;
        pre_ev  = osc_rise;
      end
      SRC_EXT:
      begin
        pre_lim = `PRE_DIV_EXT;
        pre_ev  = ext_rise;
      end
      default: pre_lim = `PRE_DIV_SYS12;
    endcase
    tick  = cfg.run && pre_ev && (pre_q == pre_lim - 6'h01);
    pre_d = pre_q;
    if (cfg.run && pre_ev)
      pre_d = tick ? 6'h00 : pre_q + 6'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // two 8-bit counters sharing one reload; receive copy restarts on a start edge
  always_comb
  begin
    tx_ovf = tick && (tl_q == `TIMER_TOP);
    rx_ovf = tick && (rxt_q == `TIMER_TOP);
    tl_d   = tick ? (tx_ovf ? cfg.reload : tl_q + 8'h01) : tl_q;
    rxt_d  = tick ? (rx_ovf ? cfg.reload : rxt_q + 8'h01) : rxt_q;
    tdiv_d = tdiv_q ^ tx_ovf;                                          // RULE15
    rdiv_d = rdiv_q ^ rx_ovf;
    if (rx_restart)
    begin
      rxt_d  = cfg.reload;                                             // RULE16
      rdiv_d = 1'b0;
    end
    tx_tick   = tx_ovf && tdiv_q;
    // first overflow after a restart lands mid start bit, then every second one
    rx_sample = rx_ovf && !rdiv_q && !rx_restart;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_q  <= 6'h00;
      tl_q   <= 8'h00;
      rxt_q  <= 8'h00;
      tdiv_q <= 1'b0;
      rdiv_q <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      tl_q   <= tl_d;
      rxt_q  <= rxt_d;
      tdiv_q <= tdiv_d;
      rdiv_q <= rdiv_d;
    end
  end

endmodule

// File: verification/remote_node.sv
// behavioural remote serial node facing the port's transmit and receive lines
`timescale 1ns/1ns
module remote_node #(
  parameter int BIT_CYC = 16
)
(
  input  wire logic clk_sys,
  input  wire logic nine_bit,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_data;
  logic       got_ninth;
  logic       got_stop;
  int         got_count;

  // line idles high so the port never sees a false start edge
  initial
  begin
    line_out  = 1'b1;
    got_count = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // send one frame lsb first; stop may be driven low to test the stop check
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    int i;
    @(negedge clk_sys);
    line_out = 1'b0;
    repeat (BIT_CYC) @(negedge clk_sys);
    for (i = 0; i < 8; i++)
    begin
      line_out = d[i];
      repeat (BIT_CYC) @(negedge clk_sys);
    end
    if (nine_bit)
    begin
      line_out = ninth;
      repeat (BIT_CYC) @(negedge clk_sys);
    end
    line_out = stop;
    repeat (BIT_CYC) @(negedge clk_sys);
    line_out = 1'b1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // capture frames mid-bit after a falling edge; a high start sample is ignored
  always
  begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    if (line_in == 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk_sys);
        got_data[i] = line_in;
      end
      if (nine_bit)
      begin
        repeat (BIT_CYC) @(posedge clk_sys);
        got_ninth = line_in;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      got_stop = line_in;
      got_count++;
    end
  end
endmodule

// File: verification/tb_async_serial_port_9bit.sv
// self-checking bench for the 9-bit capable asynchronous serial port
`timescale 1ns/1ns
`include "uart9_consts.svh"
module tb_async_serial_port_9bit;
  import uart9_pkg::*;
  logic       clk_sys;
  logic       rstn;
  sfr_bus_t   sfr;
  logic [7:0] sfr_rdata;
  logic       int_enable;
  timer_cfg_t tcfg;
  logic       rx_line;
  logic       tx_line;
  logic       irq;
  logic       nine_bit;
  logic       pin_toggle;
  int         miscompares;
  int         check_count;
  int         nf;

  // reload 0xfe from sys/4 gives a 16-cycle bit
  initial
  begin
    clk_sys     = 1'b0;
    rstn        = 1'b0;
    sfr         = '0;
    int_enable  = 1'b0;
    tcfg        = '{1'b1, SRC_SYS4, 8'hfe};
    nine_bit    = 1'b0;
    pin_toggle  = 1'b0;
    miscompares = 0;
    check_count = 0;
    nf          = 0;
  end

  always #5 clk_sys = ~clk_sys;

  // slow clock for the oscillator and pin sources: one rising edge every two cycles
  always @(negedge clk_sys)
    pin_toggle <= ~pin_toggle;

  async_serial_port_9bit i_async_serial_port_9bit (
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .sfr                  (sfr),
    .sfr_rdata            (sfr_rdata),
    .int_enable           (int_enable),
    .tcfg                 (tcfg),
    .ext_osc_pin          (pin_toggle),
    .baud_timer_ext_input (pin_toggle),
    .serial_in_pin        (rx_line),
    .serial_out_pin       (tx_line),
    .irq                  (irq)
  );

  remote_node #(.BIT_CYC(16)) i_remote_node (
    .clk_sys  (clk_sys),
    .nine_bit (nine_bit),
    .line_in  (tx_line),
    .line_out (rx_line)
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers; bus changes only at falling edges
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    sfr = '0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    sfr = '0;
    @(negedge clk_sys);
    chk(what, exp, sfr_rdata);
  endtask

  // bounded wait for the node to finish capturing the next frame; the baud
  // timer counts up from zero after reset, so the first frame starts late
  task automatic wait_tx();
    int k;
    k = 0;
    nf++;
    while (i_remote_node.got_count != nf && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 2000)
    begin
      miscompares++;
      $display("[ERR] frame capture expected %0d seen %0d", nf, i_remote_node.got_count);
    end
  endtask

  // start bit lasts one bit: two overflows of (256 - reload) timer clocks
  task automatic bit_time(input string what, input clk_src_t src, input int per);
    int n;
    n = 0;
    tcfg.src = src;
    wr(`DATA_ADDR, 8'hff);
    while (tx_line !== 1'b0 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while (tx_line === 1'b0 && n < 255)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(what, 8'(2 * (256 - int'(tcfg.reload)) * per), n[7:0]);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    rd_chk("ctrl reset", `CTRL_ADDR, `CTRL_RESET);
    rd_chk("data reset", `DATA_ADDR, `DATA_RESET);
    rd_chk("unmapped", 8'h9a, 8'h00);
    wr(`CTRL_ADDR, 8'h38);
    rd_chk("ctrl rw", `CTRL_ADDR, 8'h78);
    wr(`CTRL_ADDR, 8'h00);
    rd_chk("bit6 fixed", `CTRL_ADDR, 8'h40);
  endtask

  // tb8 low in 8-bit mode must not disturb the stop bit
  task automatic t_tx8();
    int_enable = 1'b1;
    wr(`DATA_ADDR, 8'ha5);
    wait_tx();
    chk("tx8 data", 8'ha5, i_remote_node.got_data);
    chk("tx8 stop", 8'h01, {7'h0, i_remote_node.got_stop});
    rd_chk("ti set", `CTRL_ADDR, 8'h42);
    rd_chk("no tx readback", `DATA_ADDR, 8'h00);
    chk("irq ti", 8'h01, {7'h0, irq});
    chk("tx idle", 8'h01, {7'h0, tx_line});
    wr(`CTRL_ADDR, 8'h00);
    rd_chk("ti cleared", `CTRL_ADDR, 8'h40);
    chk("irq drop", 8'h00, {7'h0, irq});
  endtask

  task automatic t_tx9();
    nine_bit = 1'b1;
    for (int b = 1; b >= 0; b--)
    begin
      wr(`CTRL_ADDR, {4'h8, b[0], 3'h0});
      wr(`DATA_ADDR, 8'h5a ^ b[7:0]);
      wait_tx();
      chk("tx9 data", 8'h5a ^ b[7:0], i_remote_node.got_data);
      chk("tx9 ninth", {7'h0, b[0]}, {7'h0, i_remote_node.got_ninth});
      rd_chk("tx9 ti", `CTRL_ADDR, {4'hc, b[0], 3'h2});
    end
    wr(`CTRL_ADDR, 8'h00);
  endtask

  task automatic t_rx8();
    nine_bit = 1'b0;
    wr(`CTRL_ADDR, 8'h10);
    i_remote_node.send(8'h3c, 1'b0, 1'b1);
    rd_chk("rx8 flags", `CTRL_ADDR, 8'h55);
    rd_chk("rx8 data", `DATA_ADDR, 8'h3c);
    chk("irq ri", 8'h01, {7'h0, irq});
    i_remote_node.send(8'hc3, 1'b0, 1'b1);
    rd_chk("overrun keep", `DATA_ADDR, 8'h3c);
    wr(`CTRL_ADDR, 8'h30);
    i_remote_node.send(8'h77, 1'b0, 1'b0);
    rd_chk("bad stop flags", `CTRL_ADDR, 8'h70);
    rd_chk("bad stop data", `DATA_ADDR, 8'h3c);
    i_remote_node.send(8'h77, 1'b0, 1'b1);
    rd_chk("good stop", `CTRL_ADDR, 8'h75);
    rd_chk("good data", `DATA_ADDR, 8'h77);
    wr(`CTRL_ADDR, 8'h00);
    i_remote_node.send(8'h11, 1'b0, 1'b1);
    rd_chk("rx off flags", `CTRL_ADDR, 8'h40);
    rd_chk("rx off data", `DATA_ADDR, 8'h77);
  endtask

  // address filter: data byte dropped, address byte kept
  task automatic t_rx9();
    nine_bit = 1'b1;
    wr(`CTRL_ADDR, 8'hb0);
    i_remote_node.send(8'h12, 1'b0, 1'b1);
    rd_chk("filt drop", `CTRL_ADDR, 8'hf0);
    rd_chk("filt data", `DATA_ADDR, 8'h77);
    i_remote_node.send(8'h34, 1'b1, 1'b0);
    rd_chk("addr flags", `CTRL_ADDR, 8'hf5);
    rd_chk("addr data", `DATA_ADDR, 8'h34);
    wr(`CTRL_ADDR, 8'h90);
    i_remote_node.send(8'h56, 1'b0, 1'b1);
    rd_chk("nofilt flags", `CTRL_ADDR, 8'hd1);
    rd_chk("nofilt data", `DATA_ADDR, 8'h56);
  endtask

  // receive flag still set: masked interrupt, then the other timer clock sources
  task automatic t_src();
    int_enable = 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(`CTRL_ADDR, 8'h00);
    bit_time("bit sys12", SRC_SYS12, `PRE_DIV_SYS12);
    bit_time("bit sys48", SRC_SYS48, `PRE_DIV_SYS48);
    bit_time("bit osc8", SRC_OSC8, 2 * `PRE_DIV_OSC8);
    bit_time("bit ext", SRC_EXT, 2 * `PRE_DIV_EXT);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // verdict, shared by the main sequence and the watchdog
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_regs();
    t_tx8();
    t_tx9();
    t_rx8();
    t_rx9();
    t_src();
    results();
  end

  // whole run needs a few thousand cycles; cut off at 60000
  initial
  begin
    #600000;
    miscompares++;
    results();
  end
endmodule
